// ===== hdl/csa_pkg.sv
// Shared constants, register map and types of the comparator status and slope converter control.
package csa_pkg;

  localparam int          CSA_DATA_W        = 32;
  localparam int          CSA_ADDR_W        = 8;
  localparam int          CSA_REG_W         = 8;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [5:0]  CSA_CTRL_INDEX    = 6'h1d;
  localparam logic [5:0]  CSA_STATUS_INDEX  = 6'h1e;

  localparam logic [7:0]  CSA_REG_RESET     = 8'h00;
  localparam logic [31:0] CSA_READ_NONE     = 32'h0000_0000;

  // Analog status register bit positions.
  localparam int          CSA_ST_FLAG2      = 7;
  localparam int          CSA_ST_FLAG1      = 6;
  localparam int          CSA_ST_CLR2       = 5;
  localparam int          CSA_ST_CLR1       = 4;
  localparam int          CSA_ST_OFFSET     = 3;
  localparam int          CSA_ST_PIN_OE     = 2;
  localparam int          CSA_ST_STATE2     = 1;
  localparam int          CSA_ST_STATE1     = 0;

  // Analog control register bit positions.
  localparam int          CSA_CT_CHARGE     = 7;
  localparam int          CSA_CT_MODE_HI    = 6;
  localparam int          CSA_CT_MODE_LO    = 5;
  localparam int          CSA_CT_ROUTE      = 4;
  localparam int          CSA_CT_IRQ_EN     = 3;
  localparam int          CSA_CT_CP2EN      = 2;
  localparam int          CSA_CT_CP1EN      = 1;
  localparam int          CSA_CT_SRC_EN     = 0;

  // Nominal offset added to the bottom of the sample capacitor.
  localparam int          CSA_OFFSET_MV     = 100;
  // Software discharge guidance for the external ramp capacitor.
  localparam int          CSA_DISCHARGE_MS_PER_UF = 10;
  localparam int          CSA_DISCHARGE_FRACTION  = 10;

  typedef enum logic [1:0] {
    CSA_MODE_MANUAL   = 2'h0,
    CSA_MODE_AUTO_DIS = 2'h1,
    CSA_MODE_TIMER_CAP   = 2'h2,
    CSA_MODE_COMPARE_CAP = 2'h3
  } csa_mode_t;

  // Sticky flag update where a new event wins over a clear in the same cycle.
  function automatic logic csa_flag_next(input logic flag, input logic set, input logic clr);
    csa_flag_next = set | (flag & ~clr);
  endfunction : csa_flag_next

endpackage : csa_pkg

// ===== hdl/csa_cmp_if.sv
// Carrier for one synchronised comparator level and its rising edge pulse.
`timescale 1ns/1ps
interface csa_cmp_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input  level, input  rise);
endinterface : csa_cmp_if

// ===== hdl/csa_cmp_sync.sv
// Synchroniser and rising edge detector for one asynchronous comparator output.
`timescale 1ns/1ps
module csa_cmp_sync #(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic  clk,
  input  wire logic  srst,
  input  wire logic  raw,
  csa_cmp_if.src     cmp
);

  logic [SYNC_STAGES-1:0] stage;
  logic                   last;

  initial begin
    if (SYNC_STAGES < 2) begin
      $error("csa_cmp_sync needs at least two stages");
    end
  end

  // The first stage feeds only the next stage.
  always_ff @(posedge clk) begin
    if (srst) begin
      stage <= '0;
    end else begin
      stage <= {stage[SYNC_STAGES-2:0], raw};
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      last <= 1'b0;
    end else begin
      last <= stage[SYNC_STAGES-1];
    end
  end

  assign cmp.level = stage[SYNC_STAGES-1];
  assign cmp.rise  = stage[SYNC_STAGES-1] & ~last;

  a_rise_single: assert property (@(posedge clk) disable iff (srst) cmp.rise |=> !cmp.rise)
    else $error("edge pulse lasted more than one cycle");

endmodule : csa_cmp_sync

// ===== hdl/csa_status_ctrl.sv
// Comparator status register, conversion control and Avalon-MM slave of the analog subsystem.
//
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
module csa_status_ctrl
  import csa_pkg::*;
#(
  parameter int SYNC_STAGES = 2
) (
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic [csa_pkg::CSA_ADDR_W-1:0] avs_address,
  input  wire logic [3:0]                  avs_byteenable,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [csa_pkg::CSA_DATA_W-1:0] avs_writedata,
  output logic      [csa_pkg::CSA_DATA_W-1:0] avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        comparator_one_raw,
  input  wire logic                        comparator_two_raw,
  input  wire logic                        extended_option_bit,
  input  wire logic                        sample_connect_hold,
  input  wire logic                        sample_connect_differential,
  input  wire logic                        port_pin_direction,
  input  wire logic                        port_pin_data,
  input  wire logic                        output_level_bit,
  input  wire logic                        timer_overflow_flag,
  input  wire logic                        output_compare_flag,
  input  wire logic                        input_capture_flag,
  input  wire logic                        capture_pin,
  output logic                             comparator_one_power,
  output logic                             comparator_two_power,
  output logic                             current_source_power,
  output logic                             charge_source_on,
  output logic                             discharge_on,
  output logic                             sample_offset_on,
  output logic                             sample_bottom_grounded,
  output logic                             comparator_output_pin_out,
  output logic                             comparator_output_pin_oe,
  output logic                             timer_capture_in,
  output logic                             analog_irq
);

  import csa_pkg::*;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  localparam logic [CSA_ADDR_W-1:0] CTRL_ADDR   = {CSA_CTRL_INDEX, 2'b00};
  localparam logic [CSA_ADDR_W-1:0] STATUS_ADDR = {CSA_STATUS_INDEX, 2'b00};

  csa_cmp_if cmp_one ();
  csa_cmp_if cmp_two ();

  logic                 ack;
  logic                 access;
  logic                 wr_ctrl;
  logic                 wr_status;
  logic [CSA_REG_W-1:0] wbyte;

  logic                 comparator_one_flag;
  logic                 comparator_two_flag;
  logic                 sample_offset_enable;
  logic                 comparator_one_pin_output_enable;
  logic                 comparator_one_state;
  logic                 comparator_two_state;
  logic                 comparator_one_flag_clear;
  logic                 comparator_two_flag_clear;
  logic                 set_one;
  logic                 set_two;

  logic                 charge_control;
  csa_mode_t            conversion_mode;
  logic                 capture_routing_enable;
  logic                 analog_interrupt_enable;
  logic                 cp2_enable;
  logic                 cp1_enable;
  logic                 current_source_enable;
  logic                 hw_charge_set;
  logic                 hw_charge_clear;

  logic [CSA_REG_W-1:0] status_value;
  logic [CSA_REG_W-1:0] ctrl_value;
  logic [CSA_DATA_W-1:0] next_readdata;

  initial begin
    if (SYNC_STAGES < 2) begin
      $error("csa_status_ctrl needs at least two synchroniser stages");
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Comparator synchronisers.

  csa_cmp_sync #(.SYNC_STAGES(SYNC_STAGES)) u_sync_one (
    .clk  (clk),
    .srst (srst),
    .raw  (comparator_one_raw),
    .cmp  (cmp_one.src)
  );

  csa_cmp_sync #(.SYNC_STAGES(SYNC_STAGES)) u_sync_two (
    .clk  (clk),
    .srst (srst),
    .raw  (comparator_two_raw),
    .cmp  (cmp_two.src)
  );

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait state per access, writes act on the releasing edge.

  assign access          = avs_read | avs_write;
  assign avs_waitrequest = access & ~ack;
  assign wbyte           = avs_writedata[CSA_REG_W-1:0];
  assign wr_ctrl         = avs_write & ack & avs_byteenable[0] & (avs_address == CTRL_ADDR);
  assign wr_status       = avs_write & ack & avs_byteenable[0] & (avs_address == STATUS_ADDR);

  always_ff @(posedge clk) begin
    if (srst) begin
      ack <= 1'b0;
    end else begin
      ack <= access & ~ack;
    end
  end

  always_comb begin
    next_readdata = CSA_READ_NONE;
    if (avs_address == CTRL_ADDR) begin
      next_readdata[CSA_REG_W-1:0] = ctrl_value;
    end else if (avs_address == STATUS_ADDR) begin
      next_readdata[CSA_REG_W-1:0] = status_value;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      avs_readdata <= CSA_READ_NONE;
    end else if (avs_read & ~ack) begin
      avs_readdata <= next_readdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Analog status register.

  assign comparator_one_state      = cmp_one.level & cp1_enable;
  assign comparator_two_state      = cmp_two.level & cp2_enable;
  assign set_one                   = cmp_one.rise & cp1_enable;
  assign set_two                   = cmp_two.rise & cp2_enable;
  assign comparator_one_flag_clear = wr_status & wbyte[CSA_ST_CLR1];
  assign comparator_two_flag_clear = wr_status & wbyte[CSA_ST_CLR2];

  always_ff @(posedge clk) begin
    if (srst) begin
      comparator_two_flag <= 1'b0;
    end else begin
      comparator_two_flag <= csa_flag_next(comparator_two_flag, set_two, comparator_two_flag_clear);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      comparator_one_flag <= 1'b0;
    end else begin
      comparator_one_flag <= csa_flag_next(comparator_one_flag, set_one, comparator_one_flag_clear);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sample_offset_enable             <= 1'b0;
      comparator_one_pin_output_enable <= 1'b0;
    end else if (wr_status) begin
      sample_offset_enable             <= wbyte[CSA_ST_OFFSET];
      comparator_one_pin_output_enable <= wbyte[CSA_ST_PIN_OE];
    end
  end

  always_comb begin
    status_value                = CSA_REG_RESET;
    status_value[CSA_ST_FLAG2]  = comparator_two_flag;
    status_value[CSA_ST_FLAG1]  = comparator_one_flag;
    status_value[CSA_ST_CLR2]   = 1'b0;
    status_value[CSA_ST_CLR1]   = 1'b0;
    status_value[CSA_ST_OFFSET] = sample_offset_enable & extended_option_bit;
    status_value[CSA_ST_PIN_OE] = comparator_one_pin_output_enable & extended_option_bit;
    status_value[CSA_ST_STATE2] = comparator_two_state;
    status_value[CSA_ST_STATE1] = comparator_one_state;
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Analog control register and conversion modes.

  assign hw_charge_set   = current_source_enable &
                           (((conversion_mode == CSA_MODE_TIMER_CAP) & timer_overflow_flag) |
                            ((conversion_mode == CSA_MODE_COMPARE_CAP) & output_compare_flag));
  assign hw_charge_clear = current_source_enable & (conversion_mode != CSA_MODE_MANUAL) &
                           input_capture_flag;

  always_ff @(posedge clk) begin
    if (srst) begin
      charge_control <= 1'b0;
    end else if (hw_charge_set) begin
      charge_control <= 1'b1;
    end else if (hw_charge_clear) begin
      charge_control <= 1'b0;
    end else if (wr_ctrl) begin
      charge_control <= wbyte[CSA_CT_CHARGE];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      conversion_mode         <= CSA_MODE_MANUAL;
      capture_routing_enable  <= 1'b0;
      analog_interrupt_enable <= 1'b0;
      cp2_enable              <= 1'b0;
      cp1_enable              <= 1'b0;
      current_source_enable   <= 1'b0;
    end else if (wr_ctrl) begin
      conversion_mode         <= csa_mode_t'({wbyte[CSA_CT_MODE_HI], wbyte[CSA_CT_MODE_LO]});
      capture_routing_enable  <= wbyte[CSA_CT_ROUTE] | wbyte[CSA_CT_MODE_HI];
      analog_interrupt_enable <= wbyte[CSA_CT_IRQ_EN];
      cp2_enable              <= wbyte[CSA_CT_CP2EN];
      cp1_enable              <= wbyte[CSA_CT_CP1EN];
      current_source_enable   <= wbyte[CSA_CT_SRC_EN];
    end
  end

  always_comb begin
    ctrl_value                 = CSA_REG_RESET;
    ctrl_value[CSA_CT_CHARGE]  = charge_control;
    ctrl_value[CSA_CT_MODE_HI] = conversion_mode[1];
    ctrl_value[CSA_CT_MODE_LO] = conversion_mode[0];
    ctrl_value[CSA_CT_ROUTE]   = capture_routing_enable;
    ctrl_value[CSA_CT_IRQ_EN]  = analog_interrupt_enable;
    ctrl_value[CSA_CT_CP2EN]   = cp2_enable;
    ctrl_value[CSA_CT_CP1EN]   = cp1_enable;
    ctrl_value[CSA_CT_SRC_EN]  = current_source_enable;
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Analog and pin controls.

  assign comparator_one_power      = cp1_enable;
  assign comparator_two_power      = cp2_enable;
  assign current_source_power      = current_source_enable;
  assign charge_source_on          = current_source_enable & charge_control;
  assign discharge_on              = current_source_enable & ~charge_control;
  assign sample_bottom_grounded    = sample_connect_hold | sample_connect_differential;
  assign sample_offset_on          = sample_offset_enable & extended_option_bit & ~sample_bottom_grounded;
  assign comparator_output_pin_oe  = port_pin_direction;
  assign comparator_output_pin_out = port_pin_direction &
                                     (port_pin_data | output_level_bit |
                                      (comparator_one_state & comparator_one_pin_output_enable &
                                       extended_option_bit));
  assign timer_capture_in          = capture_routing_enable ? comparator_two_flag : capture_pin;
  assign analog_irq                = analog_interrupt_enable & (comparator_one_flag | comparator_two_flag);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  a_flag_two_set: assert property (@(posedge clk) disable iff (srst)
    set_two |=> comparator_two_flag)
    else $error("flag two missed a rising edge");

  a_flag_two_clear: assert property (@(posedge clk) disable iff (srst)
    (comparator_two_flag_clear && !set_two) |=> !comparator_two_flag)
    else $error("flag two not cleared by write of one");

  a_flag_one_set: assert property (@(posedge clk) disable iff (srst)
    set_one |=> comparator_one_flag)
    else $error("flag one missed a rising edge");

  a_flag_one_clear: assert property (@(posedge clk) disable iff (srst)
    (comparator_one_flag_clear && !set_one) |=> !comparator_one_flag)
    else $error("flag one not cleared by write of one");

  a_clear_bits_zero: assert property (@(posedge clk) disable iff (srst)
    (avs_read && !avs_waitrequest && avs_address == STATUS_ADDR) |->
      avs_readdata[CSA_ST_CLR2:CSA_ST_CLR1] == 2'h0)
    else $error("flag clear bits read back nonzero");

  a_flag_zero_write: assert property (@(posedge clk) disable iff (srst)
    (wr_status && !wbyte[CSA_ST_CLR1] && comparator_one_flag) |=> comparator_one_flag)
    else $error("writing zero disturbed flag one");

  a_reset_status: assert property (@(posedge clk)
    srst |=> (status_value == CSA_REG_RESET))
    else $error("status register not clear after reset");

  a_offset_option: assert property (@(posedge clk) disable iff (srst)
    !extended_option_bit |-> (!sample_offset_on && (!comparator_output_pin_out ||
      port_pin_data || output_level_bit)))
    else $error("option-gated control acted while option clear");

  a_offset_ground: assert property (@(posedge clk) disable iff (srst)
    (sample_connect_hold || sample_connect_differential) |-> (sample_bottom_grounded && !sample_offset_on))
    else $error("sample bottom not grounded while connected");

  a_pin_or: assert property (@(posedge clk) disable iff (srst)
    (port_pin_direction && extended_option_bit && comparator_one_pin_output_enable && comparator_one_state)
      |-> comparator_output_pin_out)
    else $error("comparator one not seen on output pin");

  a_source_off: assert property (@(posedge clk) disable iff (srst)
    $fell(current_source_enable) |-> (!charge_source_on && !discharge_on))
    else $error("charge or discharge active with source disabled");

  a_mode_capture: assert property (@(posedge clk) disable iff (srst)
    (wr_ctrl && wbyte[CSA_CT_MODE_HI]) |=> (capture_routing_enable && timer_capture_in == comparator_two_flag))
    else $error("mode two or three did not route capture");

  a_auto_discharge: assert property (@(posedge clk) disable iff (srst)
    (hw_charge_clear && !hw_charge_set) |=> (!charge_control && (discharge_on || !current_source_enable)))
    else $error("capture event did not end charging");

  a_irq_follows: assert property (@(posedge clk) disable iff (srst)
    (analog_interrupt_enable && set_one && !wr_ctrl) |=> analog_irq)
    else $error("interrupt missing for set flag");

  a_bus_answer: assert property (@(posedge clk) disable iff (srst)
    (access && avs_waitrequest) |=> (!avs_waitrequest || !access))
    else $error("bus access not answered after one wait state");

endmodule : csa_status_ctrl

// ===== dv/csa_analog_model.sv
// Behavioural model of the comparators and the ramp capacitor on the analog side.
`timescale 1ns/1ps
module csa_analog_model #(
  parameter int THRESH = 20
) (
  input  wire logic clk,
  input  wire logic comparator_one_power,
  input  wire logic comparator_two_power,
  input  wire logic charge_source_on,
  input  wire logic discharge_on,
  input  wire logic level_one,
  output logic      comparator_one_raw,
  output logic      comparator_two_raw
);
  int   ramp = 0;
  logic tog  = 1'b0;
  // The ramp rises while charging and falls while discharging.
  always @(posedge clk) begin
    tog <= ~tog;
    if (charge_source_on && ramp < 63) ramp <= ramp + 1;
    else if (discharge_on && ramp > 0) ramp <= ramp - 1;
  end
  // A powered down comparator gives no settled level.
  assign comparator_one_raw = comparator_one_power ? level_one : tog;
  assign comparator_two_raw = comparator_two_power ? (ramp > THRESH) : tog;
endmodule : csa_analog_model

// ===== dv/tb_top.sv
// Self-checking testbench of the comparator status and slope converter control.
`timescale 1ns/1ps
module tb_top;
  import csa_pkg::*;
  localparam logic [7:0] A_CT = {csa_pkg::CSA_CTRL_INDEX, 2'b00};
  localparam logic [7:0] A_ST = {csa_pkg::CSA_STATUS_INDEX, 2'b00};
  logic        clk = 1'b0, srst = 1'b1, rd_en = 1'b0, wr_en = 1'b0, lvl1 = 1'b0, option = 1'b0;
  logic        hold = 1'b0, dconn = 1'b0, dir = 1'b0, pdat = 1'b0, lvl_out = 1'b0, t_ovf = 1'b0;
  logic        o_cmp = 1'b0, i_cap = 1'b0, cpin = 1'b1, wreq, c1r, c2r, p1, p2, ps, charging, discharging;
  logic        off_on, gnd, pin_o, pin_oe, cap_in, irq;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  int          errors = 0, n_checks = 0;
  always #50 clk = ~clk;
  csa_status_ctrl u_csa_status_ctrl (.clk(clk), .srst(srst), .avs_address(addr), .avs_byteenable(4'h1),
    .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .comparator_one_raw(c1r), .comparator_two_raw(c2r), .extended_option_bit(option), .sample_connect_hold(hold),
    .sample_connect_differential(dconn), .port_pin_direction(dir), .port_pin_data(pdat),
    .output_level_bit(lvl_out), .timer_overflow_flag(t_ovf), .output_compare_flag(o_cmp), .input_capture_flag(i_cap),
    .capture_pin(cpin), .comparator_one_power(p1), .comparator_two_power(p2), .current_source_power(ps),
    .charge_source_on(charging), .discharge_on(discharging), .sample_offset_on(off_on),
    .sample_bottom_grounded(gnd), .comparator_output_pin_out(pin_o), .comparator_output_pin_oe(pin_oe),
    .timer_capture_in(cap_in), .analog_irq(irq));
  csa_analog_model u_csa_analog_model (.clk(clk), .comparator_one_power(p1), .comparator_two_power(p2),
    .charge_source_on(charging), .discharge_on(discharging), .level_one(lvl1), .comparator_one_raw(c1r),
    .comparator_two_raw(c2r));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk);
    addr  <= a;
    wdata <= {24'h0, d};
    rd_en <= ~wr;
    wr_en <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdata[7:0];
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    if (n >= 50) check(8'h01, 8'h00, "bus timeout");
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check(q, exp, "register read");
  endtask : rd
  // The caller samples the level on a falling edge; stimulus resumes on the next rising edge.
  task automatic pin(input logic seen, input logic exp);
    check({7'h0, seen}, {7'h0, exp}, "port level");
    @(posedge clk);
  endtask : pin
  task automatic pulse(input int m);
    @(posedge clk);
    t_ovf <= (m == 2);
    o_cmp <= (m == 3);
    i_cap <= (m == 4);
    @(posedge clk);
    {t_ovf, o_cmp, i_cap} <= 3'b000;
  endtask : pulse
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : print_verdict
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    print_verdict;
  end
  initial begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rd(A_ST, 8'h00);
    rd(A_CT, 8'h00);
    @(negedge clk) pin(charging | discharging | ps | p1 | p2, 1'b0);
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00);
    $display("test reset done");
    wr(A_CT, 8'h0f);
    wr(A_ST, 8'h30);
    rd(A_ST, 8'h00);
    lvl1 <= 1'b1;
    repeat (6) @(posedge clk);
    rd(A_ST, 8'h41);
    @(negedge clk) pin(irq, 1'b1);
    lvl1 <= 1'b0;
    repeat (6) @(posedge clk);
    rd(A_ST, 8'h40);
    wr(A_ST, 8'h00);
    rd(A_ST, 8'h40);
    wr(A_ST, 8'h10);
    rd(A_ST, 8'h00);
    @(negedge clk) pin(irq, 1'b0);
    $display("test flag one done");
    wr(A_CT, 8'h87);
    @(negedge clk) pin(charging & ~discharging & ps, 1'b1);
    repeat (30) @(posedge clk);
    rd(A_ST, 8'h82);
    wr(A_CT, 8'he6);
    @(negedge clk) pin(charging | discharging | ps, 1'b0);
    wr(A_CT, 8'h07);
    @(negedge clk) pin(discharging & ~charging, 1'b1);
    repeat (40) @(posedge clk);
    rd(A_ST, 8'h80);
    wr(A_ST, 8'h20);
    rd(A_ST, 8'h00);
    $display("test ramp done");
    lvl1 <= 1'b1;
    dir  <= 1'b1;
    repeat (6) @(posedge clk);
    wr(A_ST, 8'h1c);
    rd(A_ST, 8'h01);
    @(negedge clk) pin(pin_o | off_on, 1'b0);
    option <= 1'b1;
    rd(A_ST, 8'h0d);
    @(negedge clk) pin(pin_o & pin_oe & off_on & ~gnd, 1'b1);
    hold <= 1'b1;
    @(negedge clk) pin(gnd & ~off_on, 1'b1);
    hold  <= 1'b0;
    dconn <= 1'b1;
    @(negedge clk) pin(gnd & ~off_on, 1'b1);
    dconn <= 1'b0;
    dir   <= 1'b0;
    @(negedge clk) pin(pin_oe | pin_o, 1'b0);
    lvl1 <= 1'b0;
    $display("test option done");
    for (int m = 0; m < 4; m++) begin
      wr(A_CT, 8'(m << 5) | 8'h03 | ((m < 2) ? 8'h80 : 8'h00));
      pulse(m);
      rd(A_CT, 8'(m << 5) | 8'h83 | ((m >= 2) ? 8'h10 : 8'h00));
      @(negedge clk) pin(cap_in, m < 2);
      pulse(4);
      rd(A_CT, 8'(m << 5) | 8'h03 | ((m >= 2) ? 8'h10 : 8'h00) | ((m == 0) ? 8'h80 : 8'h00));
    end
    $display("test modes done");
    print_verdict;
  end
endmodule : tb_top
